//--- verilog/smbus_cfg_pkg.sv
/*
  Constants, types and timing counts shared by the SMBus configuration slave and its strap detector.
  Assumes a single 25 MHz device clock; pins are sampled as synchronous inputs.
*/
package smbus_cfg_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ        = 25000;
  localparam int DETECT_US      = 1000;
  localparam int DETECT_CYCLES  = (DETECT_US * CLK_KHZ + 999) / 1000;
  localparam int TIMEOUT_MS     = 25;
  localparam int TIMEOUT_MAX_MS = 35;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // addressing and register space
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR_A  = 7'h2c;
  localparam logic [6:0] SLAVE_ADDR_B  = 7'h2d;
  localparam int         REG_DEPTH     = 256;
  localparam logic [7:0] LEGACY_LIMIT  = 8'h80;
  localparam logic [7:0] ATTACH_OFF    = 8'h7f;
  localparam int         ATTACH_BIT    = 0;
  localparam int         BLOCK_MAX     = 8;
  localparam logic [7:0] READ_LEN      = 8'h08;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_COUNT, ST_DATA, ST_READ, ST_SKIP} state_t;

  typedef struct packed {
    logic clk;
    logic dat;
  } smb_lines_t;

  typedef struct packed {
    logic decided;
    logic enabled;
    logic legacy;
  } strap_t;

endpackage

//--- verilog/smbus_strap_detect.sv
/*
  Power-up detection of the SMBus port: enable and legacy/advanced mode.
  Assumes the pins are synchronous inputs and reset is released with the supplies valid.
*/
`timescale 1ns/100ps
module smbus_strap_detect
  import smbus_cfg_pkg::*;
#(
  parameter int DETECT_CYC = DETECT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire smb_lines_t lines_in,
  input  wire logic       legacy_strap_in,
  output strap_t          strap_out
);

  localparam int CW = $clog2(DETECT_CYC + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          high_r;
  logic          high_nxt;
  strap_t        strap_r;
  strap_t        strap_nxt;

  // ----------------------------------------------------------------
  // detection window
  // ----------------------------------------------------------------
  always_comb begin
    cnt_nxt   = cnt_r;
    high_nxt  = high_r;
    strap_nxt = strap_r;
    if (!strap_r.decided) begin
      high_nxt = high_r & lines_in.clk & lines_in.dat;
      cnt_nxt  = cnt_r + 1'b1;
      if (cnt_r == CW'(DETECT_CYC - 1)) begin
        strap_nxt.decided = 1'b1;
        strap_nxt.enabled = high_nxt;
        strap_nxt.legacy  = high_nxt & legacy_strap_in;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r   <= '0;
      high_r  <= 1'b1;
      strap_r <= '0;
    end else begin
      cnt_r   <= cnt_nxt;
      high_r  <= high_nxt;
      strap_r <= strap_nxt;
    end
  end

  assign strap_out = strap_r;

endmodule

//--- verilog/smbus_config_slave.sv
/*
  SMBus configuration slave: block write / block read into a configuration store that overrides OTP values,
  with timeout, bus reset and power-up hold-off.
  Assumes pins are synchronous to CLOCK_IN and open-drain wires are resolved outside.
*/
// What this block does
// - port enabled only if data and clock both read high for first millisecond.
// - enabled port runs legacy (USB 2.0 registers) or advanced (all registers).
// - legacy mode chosen only when the legacy strap also reads high.
// - mode strap sampled at end of detection window and fixed afterwards.
// - when enabled, initialisation waits indefinitely until host signals configuration done.
// - any pin pulled low keeps port disabled; initialisation starts at once from OTP.
// - values written over SMBus win over values loaded from OTP.
// - only block write and block read; other protocols change no register.
// - answer only addresses 0101100b and 0101101b; ignore all others.
// - any party may abort and release once one clock-low interval exceeds 25 ms.
// - after clock-low timeout, protocol resets and accepts start within 35 ms.
// - tolerate others stretching the clock; may stretch the clock itself.
// - start immediately followed by stop resets protocol logic to idle.
// - no alert output and no alert response address participation.
// - hardware reset ends any transaction and returns registers to defaults.
`timescale 1ns/100ps
module smbus_config_slave
  import smbus_cfg_pkg::*;
#(
  parameter int DETECT_CYC  = DETECT_CYCLES,
  parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
  input  wire logic       CLOCK_IN,
  input  wire logic       RESETN_IN,
  input  wire logic       SMB_DATA_PIN_IN,
  output logic            SMB_DATA_PIN_OUT,
  output logic            SMB_DATA_PIN_OE_OUT,
  input  wire logic       SMB_CLOCK_PIN_IN,
  output logic            SMB_CLOCK_PIN_OUT,
  output logic            SMB_CLOCK_PIN_OE_OUT,
  input  wire logic       LEGACY_STRAP_IN,
  input  wire logic [7:0] CFG_SEL_IN,
  input  wire logic [7:0] OTP_DATA_IN,
  output logic      [7:0] CFG_DATA_OUT,
  output logic            SMB_ENABLED_OUT,
  output logic            LEGACY_MODE_OUT,
  output logic            INIT_GO_OUT
);

  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic reg_open(input logic [7:0] off, input logic legacy);
    return !legacy || (off < LEGACY_LIMIT);
  endfunction

  // ----------------------------------------------------------------
  // pins and strap detection
  // ----------------------------------------------------------------
  smb_lines_t lines;
  smb_lines_t prev_r;
  strap_t     strap;
  logic       rise;
  logic       fall;
  logic       start_cond;
  logic       stop_cond;

  assign lines.clk  = SMB_CLOCK_PIN_IN;
  assign lines.dat  = SMB_DATA_PIN_IN;
  assign rise       = lines.clk & ~prev_r.clk;
  assign fall       = ~lines.clk & prev_r.clk;
  assign start_cond = prev_r.dat & ~lines.dat & lines.clk & prev_r.clk;
  assign stop_cond  = ~prev_r.dat & lines.dat & lines.clk & prev_r.clk;

  smbus_strap_detect #(
    .DETECT_CYC (DETECT_CYC)
  ) u_strap (
    .clk             (CLOCK_IN),
    .rst_n           (RESETN_IN),
    .lines_in        (lines),
    .legacy_strap_in (LEGACY_STRAP_IN),
    .strap_out       (strap)
  );

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  state_t        state_r,   state_nxt;
  logic [3:0]    bitcnt_r,  bitcnt_nxt;
  logic [7:0]    shreg_r,   shreg_nxt;
  logic          reading_r, reading_nxt;
  logic          ackdrv_r,  ackdrv_nxt;
  logic          mack_r,    mack_nxt;
  logic          stretch_r, stretch_nxt;
  logic          havecmd_r, havecmd_nxt;
  logic [7:0]    cmd_r,     cmd_nxt;
  logic [3:0]    cnt_r,     cnt_nxt;
  logic [3:0]    idx_r,     idx_nxt;
  logic [TW-1:0] tocnt_r,   tocnt_nxt;
  logic [7:0]    stage_r   [BLOCK_MAX];
  logic [7:0]    stage_nxt [BLOCK_MAX];
  logic [7:0]    regs_r    [REG_DEPTH];
  logic [7:0]    regs_nxt  [REG_DEPTH];
  logic          commit;
  logic [7:0]    rd_off;
  logic [7:0]    tx_byte;

  assign rd_off  = cmd_r + {4'h0, idx_r} - 8'h01;
  assign tx_byte = (idx_r == 4'h0) ? READ_LEN :
                   (reg_open(rd_off, strap.legacy) ? regs_r[rd_off] : 8'h00);

  always_comb begin
    state_nxt   = state_r;
    bitcnt_nxt  = bitcnt_r;
    shreg_nxt   = shreg_r;
    reading_nxt = reading_r;
    ackdrv_nxt  = ackdrv_r;
    mack_nxt    = mack_r;
    stretch_nxt = 1'b0;
    havecmd_nxt = havecmd_r;
    cmd_nxt     = cmd_r;
    cnt_nxt     = cnt_r;
    idx_nxt     = idx_r;
    stage_nxt   = stage_r;
    commit      = 1'b0;
    // clock-low interval counter; saturates so the abort fires once
    if (lines.clk) begin
      tocnt_nxt = '0;
    end else if (tocnt_r != TW'(TIMEOUT_CYC)) begin
      tocnt_nxt = tocnt_r + 1'b1;
    end else begin
      tocnt_nxt = tocnt_r;
    end
    if (!strap.decided || !strap.enabled) begin
      state_nxt = ST_IDLE;
    end else if (!lines.clk && tocnt_r == TW'(TIMEOUT_CYC - 1)) begin
      state_nxt   = ST_IDLE;
      reading_nxt = 1'b0;
      ackdrv_nxt  = 1'b0;
      havecmd_nxt = 1'b0;
    end else if (start_cond) begin
      state_nxt   = ST_ADDR;
      // wraps to zero on the clock fall that closes the start, so it is not counted as a bit
      bitcnt_nxt  = 4'hf;
      reading_nxt = 1'b0;
      ackdrv_nxt  = 1'b0;
      havecmd_nxt = (state_r == ST_COUNT);
    end else if (stop_cond) begin
      commit      = (state_r == ST_DATA) && (idx_r == cnt_r);
      state_nxt   = ST_IDLE;
      reading_nxt = 1'b0;
      ackdrv_nxt  = 1'b0;
      havecmd_nxt = 1'b0;
    end else if (state_r != ST_IDLE && state_r != ST_SKIP) begin
      if (rise) begin
        if (bitcnt_r < 4'h8 && !reading_r) begin
          shreg_nxt = {shreg_r[6:0], lines.dat};
        end else if (bitcnt_r == 4'h8 && reading_r) begin
          mack_nxt = ~lines.dat;
        end
      end
      if (fall) begin
        if (bitcnt_r == 4'h7) begin
          bitcnt_nxt = 4'h8;
          if (!reading_r) begin
            unique case (state_r)
              ST_ADDR: begin
                if (shreg_r[7:1] != SLAVE_ADDR_A && shreg_r[7:1] != SLAVE_ADDR_B) begin
                  state_nxt = ST_SKIP;
                end else if (!shreg_r[0]) begin
                  ackdrv_nxt = 1'b1;
                  state_nxt  = ST_CMD;
                end else if (havecmd_r) begin
                  ackdrv_nxt  = 1'b1;
                  reading_nxt = 1'b1;
                  mack_nxt    = 1'b1;
                  idx_nxt     = 4'h0;
                  state_nxt   = ST_READ;
                end else begin
                  state_nxt = ST_SKIP;
                end
              end
              ST_CMD: begin
                cmd_nxt    = shreg_r;
                ackdrv_nxt = 1'b1;
                state_nxt  = ST_COUNT;
              end
              ST_COUNT: begin
                if (shreg_r != 8'h00 && shreg_r <= 8'(BLOCK_MAX)) begin
                  cnt_nxt    = shreg_r[3:0];
                  idx_nxt    = 4'h0;
                  ackdrv_nxt = 1'b1;
                  state_nxt  = ST_DATA;
                end else begin
                  state_nxt = ST_SKIP;
                end
              end
              ST_DATA: begin
                if (idx_r < cnt_r) begin
                  stage_nxt[idx_r[$clog2(BLOCK_MAX)-1:0]] = shreg_r;
                  idx_nxt    = idx_r + 4'h1;
                  ackdrv_nxt = 1'b1;
                end else begin
                  state_nxt = ST_SKIP;
                end
              end
              default: state_nxt = ST_SKIP;
            endcase
          end
        end else if (bitcnt_r == 4'h8) begin
          bitcnt_nxt = 4'h0;
          ackdrv_nxt = 1'b0;
          if (reading_r) begin
            if (mack_r) begin
              shreg_nxt   = tx_byte;
              idx_nxt     = idx_r + 4'h1;
              stretch_nxt = 1'b1;
            end else begin
              reading_nxt = 1'b0;
              state_nxt   = ST_SKIP;
            end
          end
        end else begin
          bitcnt_nxt = bitcnt_r + 4'h1;
          if (reading_r) begin
            shreg_nxt = {shreg_r[6:0], 1'b1};
          end
        end
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      prev_r    <= '1;
      state_r   <= ST_IDLE;
      bitcnt_r  <= 4'h0;
      shreg_r   <= 8'h00;
      reading_r <= 1'b0;
      ackdrv_r  <= 1'b0;
      mack_r    <= 1'b0;
      stretch_r <= 1'b0;
      havecmd_r <= 1'b0;
      cmd_r     <= 8'h00;
      cnt_r     <= 4'h0;
      idx_r     <= 4'h0;
      tocnt_r   <= '0;
      for (int i = 0; i < BLOCK_MAX; i++) begin
        stage_r[i] <= 8'h00;
      end
    end else begin
      prev_r    <= lines;
      state_r   <= state_nxt;
      bitcnt_r  <= bitcnt_nxt;
      shreg_r   <= shreg_nxt;
      reading_r <= reading_nxt;
      ackdrv_r  <= ackdrv_nxt;
      mack_r    <= mack_nxt;
      stretch_r <= stretch_nxt;
      havecmd_r <= havecmd_nxt;
      cmd_r     <= cmd_nxt;
      cnt_r     <= cnt_nxt;
      idx_r     <= idx_nxt;
      tocnt_r   <= tocnt_nxt;
      stage_r   <= stage_nxt;
    end
  end

  // ----------------------------------------------------------------
  // configuration store
  // ----------------------------------------------------------------
  logic set_r [REG_DEPTH];
  logic set_nxt [REG_DEPTH];
  logic done_r, done_nxt;

  always_comb begin
    logic [7:0] off;
    off      = 8'h00;
    regs_nxt = regs_r;
    set_nxt  = set_r;
    done_nxt = done_r;
    if (commit) begin
      for (int i = 0; i < BLOCK_MAX; i++) begin
        off = cmd_r + 8'(i);
        if (4'(i) < cnt_r && reg_open(off, strap.legacy)) begin
          regs_nxt[off] = stage_r[i];
          set_nxt[off]  = 1'b1;
          if (off == ATTACH_OFF && stage_r[i][ATTACH_BIT]) begin
            done_nxt = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      done_r <= 1'b0;
      for (int i = 0; i < REG_DEPTH; i++) begin
        regs_r[i] <= REG_RESET_VAL;
        set_r[i]  <= 1'b0;
      end
    end else begin
      done_r <= done_nxt;
      regs_r <= regs_nxt;
      set_r  <= set_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [7:0] cfg_r, cfg_nxt;
  logic       go_r,  go_nxt;

  always_comb begin
    cfg_nxt = set_r[CFG_SEL_IN] ? regs_r[CFG_SEL_IN] : OTP_DATA_IN;
    go_nxt  = strap.decided & (~strap.enabled | done_r);
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cfg_r <= 8'h00;
      go_r  <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      go_r  <= go_nxt;
    end
  end

  // open drain: only ever pull low; no alert pin exists
  assign SMB_DATA_PIN_OUT     = 1'b0;
  assign SMB_DATA_PIN_OE_OUT  = ackdrv_r | (reading_r & (bitcnt_r < 4'h8) & ~shreg_r[7]);
  assign SMB_CLOCK_PIN_OUT    = 1'b0;
  assign SMB_CLOCK_PIN_OE_OUT = stretch_r;
  assign CFG_DATA_OUT         = cfg_r;
  assign SMB_ENABLED_OUT      = strap.enabled;
  assign LEGACY_MODE_OUT      = strap.legacy;
  assign INIT_GO_OUT          = go_r;

endmodule

//--- verilog/dummy_unused_none.sv
`timescale 1ns/100ps

//--- dv/smbus_config_slave_monitor.sv
/*
  Checker for the SMBus configuration slave, bound to its top module.
  Assumes one clock domain and open-drain wires resolved outside the slave.
*/
`timescale 1ns/100ps
module smbus_config_slave_monitor
  import smbus_cfg_pkg::*;
#(
  parameter int DETECT_CYC  = DETECT_CYCLES,
  parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
  input wire logic       CLOCK_IN,
  input wire logic       RESETN_IN,
  input wire logic       SMB_DATA_PIN_IN,
  input wire logic       SMB_DATA_PIN_OUT,
  input wire logic       SMB_DATA_PIN_OE_OUT,
  input wire logic       SMB_CLOCK_PIN_IN,
  input wire logic       SMB_CLOCK_PIN_OUT,
  input wire logic       SMB_CLOCK_PIN_OE_OUT,
  input wire logic       LEGACY_STRAP_IN,
  input wire logic [7:0] CFG_SEL_IN,
  input wire logic [7:0] OTP_DATA_IN,
  input wire logic [7:0] CFG_DATA_OUT,
  input wire logic       SMB_ENABLED_OUT,
  input wire logic       LEGACY_MODE_OUT,
  input wire logic       INIT_GO_OUT
);
  int cyc_r, cyc_nxt, low_r, low_nxt, hi_r, hi_nxt;
  always_comb begin
    cyc_nxt = cyc_r + 1;
    low_nxt = SMB_CLOCK_PIN_IN ? 0 : low_r + 1;
    hi_nxt  = (SMB_CLOCK_PIN_IN && SMB_DATA_PIN_IN) ? hi_r + 1 : 0;
  end
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cyc_r <= 0;
      low_r <= 0;
      hi_r  <= 0;
    end else begin
      cyc_r <= cyc_nxt;
      low_r <= low_nxt;
      hi_r  <= hi_nxt;
    end
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_window_quiet: assert property (cyc_r < DETECT_CYC - 1 |-> !SMB_ENABLED_OUT && !INIT_GO_OUT)
    else $error("decision seen before the detection window ended");
  a_enable_pins: assert property ($rose(SMB_ENABLED_OUT) |-> hi_r >= DETECT_CYC - 1)
    else $error("port enabled without both lines high for the window");
  a_mode_fixed: assert property (!$fell(SMB_ENABLED_OUT) && !$fell(LEGACY_MODE_OUT))
    else $error("enable or mode changed after the decision");
  a_legacy_cause: assert property ($rose(LEGACY_MODE_OUT) |-> SMB_ENABLED_OUT && LEGACY_STRAP_IN)
    else $error("legacy mode without enable and strap");
  a_disabled_go: assert property (cyc_r == DETECT_CYC + 4 && !SMB_ENABLED_OUT |-> INIT_GO_OUT)
    else $error("disabled port did not start initialisation");
  a_disabled_quiet: assert property (!SMB_ENABLED_OUT |-> !SMB_DATA_PIN_OE_OUT && !SMB_CLOCK_PIN_OE_OUT)
    else $error("disabled port drove a line");
  a_go_after_stop: assert property ($rose(INIT_GO_OUT) && SMB_ENABLED_OUT
                                    |-> $past(SMB_DATA_PIN_IN) && $past(SMB_CLOCK_PIN_IN))
    else $error("initialisation released outside a stop");
  a_stretch_pulse: assert property ($rose(SMB_CLOCK_PIN_OE_OUT)
                                    |-> !$past(SMB_CLOCK_PIN_IN) ##1 !SMB_CLOCK_PIN_OE_OUT)
    else $error("clock stretch not a single low-phase cycle");
  a_data_on_low: assert property ($changed(SMB_DATA_PIN_OE_OUT) |-> !$past(SMB_CLOCK_PIN_IN))
    else $error("data line changed while clock high");
  a_timeout_free: assert property (low_r == TIMEOUT_CYC + 3
                                   |-> !SMB_DATA_PIN_OE_OUT && !SMB_CLOCK_PIN_OE_OUT)
    else $error("lines not released after clock-low timeout");
  a_open_drain: assert property (SMB_DATA_PIN_OUT == 1'b0 && SMB_CLOCK_PIN_OUT == 1'b0)
    else $error("open-drain output level not low");
endmodule
bind smbus_config_slave smbus_config_slave_monitor #(.DETECT_CYC(DETECT_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) mon (
  .CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN), .SMB_DATA_PIN_IN(SMB_DATA_PIN_IN),
  .SMB_DATA_PIN_OUT(SMB_DATA_PIN_OUT), .SMB_DATA_PIN_OE_OUT(SMB_DATA_PIN_OE_OUT),
  .SMB_CLOCK_PIN_IN(SMB_CLOCK_PIN_IN), .SMB_CLOCK_PIN_OUT(SMB_CLOCK_PIN_OUT),
  .SMB_CLOCK_PIN_OE_OUT(SMB_CLOCK_PIN_OE_OUT), .LEGACY_STRAP_IN(LEGACY_STRAP_IN), .CFG_SEL_IN(CFG_SEL_IN),
  .OTP_DATA_IN(OTP_DATA_IN), .CFG_DATA_OUT(CFG_DATA_OUT), .SMB_ENABLED_OUT(SMB_ENABLED_OUT),
  .LEGACY_MODE_OUT(LEGACY_MODE_OUT), .INIT_GO_OUT(INIT_GO_OUT));

//--- dv/smbus_host_model.sv
/*
  Behavioural SMBus host that configures the slave over open-drain lines.
  Assumes pull-ups on both lines; a strap input can pull data low.
*/
`timescale 1ns/100ps
module smbus_host_model (
  input  wire logic clk,
  input  wire logic dev_sda_oe,
  input  wire logic dev_scl_oe,
  input  wire logic sda_low_strap,
  output wire logic sda,
  output wire logic scl
);
  localparam int HALF = 4;
  logic h_sda = 1'b0;
  logic h_scl = 1'b0;
  // a released wire reads high through its pull-up
  assign sda = ~(h_sda | dev_sda_oe | sda_low_strap);
  assign scl = ~(h_scl | dev_scl_oe);
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic step(input logic d, input logic c);
    h_sda = d;
    h_scl = c;
    wait_n(HALF);
  endtask
  task automatic put_bit(input logic b, output logic r);
    step(~b, 1'b1);
    h_scl = 1'b0;
    for (int g = 0; g < 64 && !scl; g++) wait_n(1);
    wait_n(HALF);
    r = sda;
    h_scl = 1'b1;
  endtask
  task automatic xfer(input logic [7:0] b, input logic ack_in, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(b[i], r[i]);
    put_bit(ack_in, ack);
  endtask
  task automatic start();
    step(1'b0, h_scl);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic stop();
    step(h_sda, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic hold_low(input int n);
    h_scl = 1'b1;
    wait_n(n);
  endtask
endmodule

//--- dv/smbus_config_slave_tb.sv
/*
  Self-checking bench for the SMBus configuration slave.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
module smbus_config_slave_tb;
  import smbus_cfg_pkg::*;
  localparam int DET = 20;
  localparam int TMO = 200;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        strap = 1'b0;
  logic        low_strap = 1'b0;
  logic [7:0]  sel = 8'h00;
  logic [31:0] rng = 32'd77653;
  logic [7:0]  mem [256];
  logic        wr [256];
  logic [7:0]  wd [8];
  logic [7:0]  exp_q [$];
  logic [7:0]  obs_q [$];
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;
  wire         sda, scl, d_oe, c_oe, en, lg, go;
  wire  [7:0]  cfg;
  wire  [7:0]  otp = sel ^ 8'ha5;
  smbus_config_slave #(.DETECT_CYC(DET), .TIMEOUT_CYC(TMO)) dut (
    .CLOCK_IN(clk), .RESETN_IN(rst_n), .SMB_DATA_PIN_IN(sda), .SMB_DATA_PIN_OUT(), .SMB_DATA_PIN_OE_OUT(d_oe),
    .SMB_CLOCK_PIN_IN(scl), .SMB_CLOCK_PIN_OUT(), .SMB_CLOCK_PIN_OE_OUT(c_oe), .LEGACY_STRAP_IN(strap),
    .CFG_SEL_IN(sel), .OTP_DATA_IN(otp), .CFG_DATA_OUT(cfg), .SMB_ENABLED_OUT(en), .LEGACY_MODE_OUT(lg),
    .INIT_GO_OUT(go));
  smbus_host_model host (.clk(clk), .dev_sda_oe(d_oe), .dev_scl_oe(c_oe), .sda_low_strap(low_strap),
                         .sda(sda), .scl(scl));
  initial forever #20 clk = ~clk;
  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic note(input logic [7:0] seen, input logic [7:0] want);
    exp_q.push_back(want);
    obs_q.push_back(seen);
  endtask
  initial forever begin
    wait (obs_q.size() > 0);
    check(obs_q.pop_front(), exp_q.pop_front());
  end
  task automatic conclude();
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic do_reset(input logic leg, input logic low, input int hold);
    rst_n = 1'b0;
    strap = leg;
    low_strap = low;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
      wr[i] = 1'b0;
    end
    repeat (hold) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (DET + 6) @(posedge clk);
    #1;
  endtask
  task automatic blk_write(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] cnt, input int n,
                           input logic commit, output logic ok);
    logic [7:0] r;
    logic       k;
    host.start();
    host.xfer({a, 1'b0}, 1'b1, r, k);
    ok = !k;
    host.xfer(cmd, 1'b1, r, k);
    ok = ok && !k;
    host.xfer(cnt, 1'b1, r, k);
    ok = ok && !k;
    for (int i = 0; i < n; i++) begin
      host.xfer(wd[i], 1'b1, r, k);
      ok = ok && !k;
      if (commit) mem[8'(cmd + i)] = wd[i];
      if (commit) wr[8'(cmd + i)] = 1'b1;
    end
    host.stop();
  endtask
  task automatic blk_read(input logic [7:0] cmd);
    logic [7:0] r;
    logic       k;
    host.start();
    host.xfer({SLAVE_ADDR_A, 1'b0}, 1'b1, r, k);
    host.xfer(cmd, 1'b1, r, k);
    host.start();
    host.xfer({SLAVE_ADDR_A, 1'b1}, 1'b1, r, k);
    host.xfer(8'hff, 1'b0, r, k);
    note(r, READ_LEN);
    for (int i = 0; i < 8; i++) begin
      host.xfer(8'hff, i == 7, r, k);
      note(r, mem[8'(cmd + i)]);
    end
    host.stop();
  endtask
  task automatic cfg_chk(input logic [7:0] o);
    sel = o;
    repeat (2) @(posedge clk);
    #1 note(cfg, wr[o] ? mem[o] : (o ^ 8'ha5));
  endtask
  initial begin
    logic       ok;
    logic [7:0] r;
    logic       k;
    do_reset(1'b0, 1'b1, 4);
    note({6'h0, en, go}, 8'h01);
    low_strap = 1'b0;
    wd[0] = rnd();
    blk_write(SLAVE_ADDR_A, 8'h10, 8'h01, 1, 1'b0, ok);
    note({7'h0, ok}, 8'h00);
    do_reset(1'b1, 1'b0, 25);
    note({6'h0, en, lg}, 8'h03);
    wd[0] = rnd() & 8'hf0;
    blk_write(SLAVE_ADDR_A, 8'h80, 8'h01, 1, 1'b0, ok);
    cfg_chk(8'h80);
    do_reset(1'b0, 1'b0, 25);
    note({5'h0, en, lg, go}, 8'h04);
    for (int i = 0; i < 8; i++) wd[i] = rnd();
    blk_write(SLAVE_ADDR_A, 8'h10, 8'h08, 8, 1'b1, ok);
    note({7'h0, ok}, 8'h01);
    blk_write(SLAVE_ADDR_B, 8'hfc, 8'h02, 2, 1'b1, ok);
    note({7'h0, ok}, 8'h01);
    for (int i = 8'h0f; i < 8'h19; i++) cfg_chk(8'(i));
    blk_read(8'h12);
    blk_read(8'hfc);
    for (int j = 0; j < 3; j++) begin
      blk_write(7'h2b + 7'(j * 3), 8'h20, 8'h01, 1, 1'b0, ok);
      note({7'h0, ok}, 8'h00);
    end
    blk_write(SLAVE_ADDR_A, 8'h20, 8'h00, 0, 1'b0, ok);
    note({7'h0, ok}, 8'h00);
    blk_write(SLAVE_ADDR_A, 8'h20, 8'h09, 8, 1'b0, ok);
    note({7'h0, ok}, 8'h00);
    blk_write(SLAVE_ADDR_A, 8'h20, 8'h03, 2, 1'b0, ok);
    cfg_chk(8'h20);
    host.start();
    host.xfer({SLAVE_ADDR_A, 1'b0}, 1'b1, r, k);
    host.step(1'b0, 1'b1);
    host.step(1'b0, 1'b0);
    host.step(1'b1, 1'b0);
    host.step(1'b0, 1'b0);
    wd[0] = rnd();
    blk_write(SLAVE_ADDR_A, 8'h21, 8'h01, 1, 1'b1, ok);
    note({7'h0, ok}, 8'h01);
    host.start();
    host.xfer({SLAVE_ADDR_B, 1'b0}, 1'b1, r, k);
    for (int i = 7; i >= 0; i--) host.put_bit(1'(8'h22 >> i), k);
    host.hold_low(TMO + 40);
    host.stop();
    wd[0] = rnd();
    blk_write(SLAVE_ADDR_B, 8'h22, 8'h01, 1, 1'b1, ok);
    note({7'h0, ok, go}, 8'h02);
    cfg_chk(8'h22);
    wd[0] = 8'h01;
    blk_write(SLAVE_ADDR_A, ATTACH_OFF, 8'h01, 1, 1'b1, ok);
    repeat (3) @(posedge clk);
    #1 note({7'h0, go}, 8'h01);
    do_reset(1'b0, 1'b0, 25);
    cfg_chk(8'h10);
    note({7'h0, go}, 8'h00);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule
